// >>> ccr_map.vh
// Control register bank numbers, field positions, reset values and timing
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

`define CCR_NUM_W 5
`define CCR_NUM_COUNT 32
`define CCR_DATA_W 32

`define CCR_N_STATE 5'h00
`define CCR_N_EXC_SAVED 5'h01
`define CCR_N_BRK_SAVED 5'h02
`define CCR_N_IRQ_MASK 5'h03
`define CCR_N_IRQ_WAIT 5'h04
`define CCR_N_IDENT 5'h05
`define CCR_N_RSVD6 5'h06
`define CCR_N_EXC_CAUSE 5'h07
`define CCR_N_PAGE_PTR 5'h08
`define CCR_N_XLT_ACCESS 5'h09
`define CCR_N_XLT_MISC 5'h0A
`define CCR_N_ERR_INJ 5'h0B
`define CCR_N_FAULT_ADDR 5'h0C
`define CCR_N_CORE_CFG 5'h0D
`define CCR_N_PROT_BASE 5'h0E
`define CCR_N_PROT_ACCESS 5'h0F
`define CCR_N_RSVD_FIRST 5'h10

`define CCR_STATE_PIE 0
`define CCR_STATE_USER 1

`define CCR_RST_STATE 32'h00000000
`define CCR_RST_ZERO 32'h00000000

`define CCR_ACK_LATENCY 1

`endif

// >>> ccr_decode.v
// Control register number decoder honouring the build options
`default_nettype none
`include "ccr_map.vh"

module ccr_decode #(
  parameter HAS_EXT_IRQ = 0,
  parameter HAS_MMU = 0,
  parameter HAS_ECC = 0,
  parameter HAS_MPU = 0
) (
  input wire [`CCR_NUM_W-1:0] num,
  output wire exists,
  output wire [`CCR_NUM_COUNT-1:0] exists_vec
);

  ////////////////////////////////////////////////////////////////////////////
  function built;
    input integer k;
    begin
      if (k >= `CCR_N_RSVD_FIRST)
        built = 1'b0;
      else if (k == `CCR_N_RSVD6)
        built = 1'b0;
      else if (k == `CCR_N_IRQ_MASK || k == `CCR_N_IRQ_WAIT)
        built = (HAS_EXT_IRQ == 0);
      else if (k >= `CCR_N_PAGE_PTR && k <= `CCR_N_XLT_MISC)
        built = (HAS_MMU != 0);
      else if (k == `CCR_N_ERR_INJ)
        built = (HAS_ECC != 0);
      else if (k == `CCR_N_CORE_CFG)
        built = (HAS_MPU != 0) || (HAS_ECC != 0);
      else if (k == `CCR_N_PROT_BASE || k == `CCR_N_PROT_ACCESS)
        built = (HAS_MPU != 0);
      else
        built = 1'b1;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `CCR_NUM_COUNT; g = g + 1)
    begin : g_num
      assign exists_vec[g] = built(g);
    end
  endgenerate

  assign exists = exists_vec[num];

endmodule
`default_nettype wire

// >>> ccr_bank.v
// Control register bank reached by the control read/write instruction port
`default_nettype none
`include "ccr_map.vh"

module ccr_bank #(
  parameter HAS_EXT_IRQ = 0,
  parameter HAS_MMU = 0,
  parameter HAS_ECC = 0,
  parameter HAS_MPU = 0,
  // Arbitrary value, set per core at build time
  parameter [31:0] PROC_ID = 32'h0000A5C3
) (
  input wire clk,
  input wire rst_n,
  input wire ctl_rd_req,
  input wire ctl_wr_req,
  input wire [`CCR_NUM_W-1:0] ctl_num,
  input wire [31:0] ctl_wdata,
  input wire exc_entry,
  input wire brk_entry,
  input wire exc_return,
  input wire brk_return,
  input wire [31:0] exc_cause_in,
  input wire [31:0] exc_addr_in,
  input wire [31:0] irq_lines,
  output reg [31:0] ctl_rdata_q,
  output reg ctl_ack_q,
  output reg ctl_priv_fault_q,
  output reg [31:0] state_q,
  output reg [31:0] irq_mask_q,
  output reg [31:0] irq_wait_q,
  output reg [31:0] core_cfg_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Request qualification

  wire num_exists;
  wire [`CCR_NUM_COUNT-1:0] exists_vec;
  wire supervisor;
  wire rd_ok;
  wire wr_ok;
  wire [`CCR_NUM_COUNT-1:0] wr_hot;

  ccr_decode #(
    .HAS_EXT_IRQ(HAS_EXT_IRQ),
    .HAS_MMU(HAS_MMU),
    .HAS_ECC(HAS_ECC),
    .HAS_MPU(HAS_MPU)
  ) u_decode (
    .num(ctl_num),
    .exists(num_exists),
    .exists_vec(exists_vec)
  );

  assign supervisor = ~state_q[`CCR_STATE_USER];
  // Instruction port is the only software path in; exception and break events also write state and saved copies, exception entry also cause and fault address
  assign rd_ok = ctl_rd_req & supervisor;
  assign wr_ok = ctl_wr_req & supervisor & ~ctl_rd_req;
  // Unbuilt numbers never get a strobe, so their writes vanish
  assign wr_hot = (wr_ok & num_exists) ? exists_vec & ({{(`CCR_NUM_COUNT-1){1'b0}}, 1'b1} << ctl_num)
                                       : {`CCR_NUM_COUNT{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // Processor state and its saved copies

  reg [31:0] exc_saved_q;
  reg [31:0] brk_saved_q;
  reg [31:0] exc_cause_q;
  reg [31:0] fault_addr_q;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= `CCR_RST_STATE;
      exc_saved_q <= `CCR_RST_ZERO;
      brk_saved_q <= `CCR_RST_ZERO;
    end
    else if (brk_entry)
    begin
      // Hardware events win over an instruction write in the same cycle
      brk_saved_q <= state_q;
      state_q[`CCR_STATE_USER] <= 1'b0;
      state_q[`CCR_STATE_PIE] <= 1'b0;
    end
    else if (exc_entry)
    begin
      exc_saved_q <= state_q;
      state_q[`CCR_STATE_USER] <= 1'b0;
      state_q[`CCR_STATE_PIE] <= 1'b0;
    end
    else if (brk_return)
      state_q <= brk_saved_q;
    else if (exc_return)
      state_q <= exc_saved_q;
    else
    begin
      // Undefined bits are stored as written; software keeps them zero
      if (wr_hot[`CCR_N_STATE])
        state_q <= ctl_wdata;
      if (wr_hot[`CCR_N_EXC_SAVED])
        exc_saved_q <= ctl_wdata;
      if (wr_hot[`CCR_N_BRK_SAVED])
        brk_saved_q <= ctl_wdata;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      exc_cause_q <= `CCR_RST_ZERO;
      fault_addr_q <= `CCR_RST_ZERO;
    end
    else if (exc_entry)
    begin
      exc_cause_q <= exc_cause_in;
      fault_addr_q <= exc_addr_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read view, one slot per number; plain read/write registers for the listed numbers

  wire [31:0] slot_w [0:`CCR_NUM_COUNT-1];

  genvar g;
  generate
    for (g = 0; g < `CCR_NUM_COUNT; g = g + 1)
    begin : g_slot
      if (g == `CCR_N_IRQ_MASK || (g >= `CCR_N_PAGE_PTR && g <= `CCR_N_ERR_INJ) ||
          (g >= `CCR_N_CORE_CFG && g <= `CCR_N_PROT_ACCESS))
      begin : g_rw
        reg [31:0] slot_q;
        always @(posedge clk)
        begin
          if (!rst_n)
            slot_q <= `CCR_RST_ZERO;
          else if (wr_hot[g])
            slot_q <= ctl_wdata;
        end
        assign slot_w[g] = exists_vec[g] ? slot_q : 32'h00000000;
      end
      else if (g == `CCR_N_STATE)
      begin : g_st
        assign slot_w[g] = state_q;
      end
      else if (g == `CCR_N_EXC_SAVED)
      begin : g_es
        assign slot_w[g] = exc_saved_q;
      end
      else if (g == `CCR_N_BRK_SAVED)
      begin : g_bs
        assign slot_w[g] = brk_saved_q;
      end
      else if (g == `CCR_N_IRQ_WAIT)
      begin : g_iw
        assign slot_w[g] = exists_vec[g] ? irq_wait_q : 32'h00000000;
      end
      else if (g == `CCR_N_IDENT)
      begin : g_id
        assign slot_w[g] = PROC_ID;
      end
      else if (g == `CCR_N_EXC_CAUSE)
      begin : g_ec
        assign slot_w[g] = exc_cause_q;
      end
      else if (g == `CCR_N_FAULT_ADDR)
      begin : g_fa
        assign slot_w[g] = fault_addr_q;
      end
      else
      begin : g_rsvd
        assign slot_w[g] = 32'h00000000;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt view and exported configuration

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_mask_q <= `CCR_RST_ZERO;
      irq_wait_q <= `CCR_RST_ZERO;
      core_cfg_q <= `CCR_RST_ZERO;
    end
    else
    begin
      // With the external controller port irq_mask_q and irq_wait_q stay zero
      irq_mask_q <= exists_vec[`CCR_N_IRQ_MASK] ? slot_w[`CCR_N_IRQ_MASK] : 32'h00000000;
      irq_wait_q <= exists_vec[`CCR_N_IRQ_WAIT] ? (irq_lines & slot_w[`CCR_N_IRQ_MASK]) : 32'h00000000;
      core_cfg_q <= slot_w[`CCR_N_CORE_CFG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer to the instruction port, one cycle after the request

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctl_rdata_q <= `CCR_RST_ZERO;
      ctl_ack_q <= 1'b0;
      ctl_priv_fault_q <= 1'b0;
    end
    else
    begin
      ctl_ack_q <= rd_ok | wr_ok;
      ctl_priv_fault_q <= (ctl_rd_req | ctl_wr_req) & ~supervisor;
      if (rd_ok)
        ctl_rdata_q <= num_exists ? slot_w[ctl_num] : 32'h00000000;
      else
        ctl_rdata_q <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// >>> ccr_bank_sva.sv
// Port-level checks for the control register bank
`default_nettype none
`include "ccr_map.vh"
module ccr_bank_sva #(
  parameter [31:0] PROC_ID = 32'h00000000,
  parameter CFG_ON = 1,
  parameter MASK_ON = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ctl_rd_req,
  input wire logic ctl_wr_req,
  input wire logic [4:0] ctl_num,
  input wire logic [31:0] ctl_wdata,
  input wire logic [31:0] ctl_rdata_q,
  input wire logic ctl_ack_q,
  input wire logic ctl_priv_fault_q,
  input wire logic [31:0] state_q,
  input wire logic [31:0] irq_mask_q,
  input wire logic [31:0] core_cfg_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic req = ctl_rd_req | ctl_wr_req;
  wire logic usr = state_q[`CCR_STATE_USER];
  wire logic wr3 = ctl_wr_req && !ctl_rd_req && ctl_num == 5'h03;
  a_ack_in_super: assert property (req && !usr |=> ctl_ack_q && !ctl_priv_fault_q)
    else $error("no ack");
  a_fault_in_user: assert property (req && usr |=> ctl_priv_fault_q && !ctl_ack_q && ctl_rdata_q == 0)
    else $error("user request not refused");
  a_no_stray_ack: assert property (!req |=> !ctl_ack_q && !ctl_priv_fault_q)
    else $error("answer without request");
  a_rsvd_reads_zero: assert property (ctl_rd_req && (ctl_num == 5'h06 || ctl_num[4]) |=> ctl_rdata_q == 0)
    else $error("reserved read not zero");
  a_ident_read: assert property (ctl_rd_req && !usr && ctl_num == 5'h05 |=> ctl_rdata_q == PROC_ID)
    else $error("bad identifier");
  a_mask_takes_write: assert property (wr3 && !usr |=> ##1 irq_mask_q == (MASK_ON ? $past(ctl_wdata, 2) : 32'h0))
    else $error("mask write lost");
  a_user_mask_kept: assert property (ctl_wr_req && usr |=> ##1 $stable(irq_mask_q))
    else $error("user write changed mask");
  a_cfg_takes_write: assert property (ctl_wr_req && !ctl_rd_req && !usr && ctl_num == 5'h0D
    |=> ##1 core_cfg_q == (CFG_ON ? $past(ctl_wdata, 2) : 32'h0))
    else $error("config write lost");
endmodule
bind ccr_bank ccr_bank_sva #(.PROC_ID(PROC_ID), .CFG_ON(HAS_MPU | HAS_ECC), .MASK_ON(HAS_EXT_IRQ == 0))
  i_ccr_bank_sva (.clk, .rst_n,
  .ctl_rd_req, .ctl_wr_req, .ctl_num, .ctl_wdata, .ctl_rdata_q, .ctl_ack_q, .ctl_priv_fault_q, .state_q,
  .irq_mask_q, .core_cfg_q);
`default_nettype wire

// >>> ccr_bank_tb.sv
// Self-checking bench for the control register bank
`default_nettype none
`include "ccr_map.vh"
module ccr_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] PID = 32'h00003C5A; // Arbitrary
  localparam [31:0] PID_B = 32'h000069E1; // Arbitrary
  localparam [31:0] LINES = 32'h0000F00F;
  logic brk_entry = 1'b0;
  logic exc_return = 1'b0;
  logic brk_return = 1'b0;
  logic [31:0] got_b, rdata_b, state_b, mask_b, wait_b, cfg_b;
  logic ack_b, fault_b;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ctl_rd_req = 1'b0;
  logic ctl_wr_req = 1'b0;
  logic exc_entry = 1'b0;
  logic usr = 1'b0;
  logic [4:0] ctl_num = 5'h00;
  logic [31:0] ctl_wdata = 32'h0, cause = 32'h0, addr = 32'h0, got;
  logic [31:0] ctl_rdata_q, state_q, irq_mask_q, irq_wait_q, core_cfg_q;
  logic ctl_ack_q, ctl_priv_fault_q;
  int bad_count = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  // MMU and MPU built, ECC left out so number 11 stays reserved
  ccr_bank #(.HAS_MMU(1), .HAS_MPU(1), .PROC_ID(PID)) i_ccr_bank (.clk, .rst_n, .ctl_rd_req, .ctl_wr_req,
    .ctl_num, .ctl_wdata, .exc_entry, .brk_entry, .exc_return, .brk_return,
    .exc_cause_in(cause), .exc_addr_in(addr), .irq_lines(LINES), .ctl_rdata_q, .ctl_ack_q,
    .ctl_priv_fault_q, .state_q, .irq_mask_q, .irq_wait_q, .core_cfg_q);
  // Second build: external controller port and ECC, no MMU or MPU
  ccr_bank #(.HAS_EXT_IRQ(1), .HAS_ECC(1), .PROC_ID(PID_B)) i_ccr_bank_b (.clk, .rst_n, .ctl_rd_req, .ctl_wr_req,
    .ctl_num, .ctl_wdata, .exc_entry, .brk_entry, .exc_return, .brk_return,
    .exc_cause_in(cause), .exc_addr_in(addr), .irq_lines(LINES), .ctl_rdata_q(rdata_b), .ctl_ack_q(ack_b),
    .ctl_priv_fault_q(fault_b), .state_q(state_b), .irq_mask_q(mask_b), .irq_wait_q(wait_b), .core_cfg_q(cfg_b));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One instruction; answer sampled half a cycle after the taking edge
  task automatic acc(input logic r, input logic [4:0] n, input logic [31:0] d);
    @(negedge clk);
    ctl_rd_req = r;
    ctl_wr_req = ~r;
    ctl_num = n;
    ctl_wdata = d;
    @(negedge clk);
    ctl_rd_req = 1'b0;
    ctl_wr_req = 1'b0;
    got = ctl_rdata_q;
    got_b = rdata_b;
    chk({28'h0, fault_b, ack_b, ctl_priv_fault_q, ctl_ack_q}, {28'h0, usr, ~usr, usr, ~usr});
  endtask
  function automatic logic [31:0] exp_b_of(input logic [4:0] n);
    case (n)
      5'h01, 5'h02, 5'h0B, 5'h0D: exp_b_of = {11'h000, n, 8'hA4, 3'h0, n};
      5'h05: exp_b_of = PID_B;
      default: exp_b_of = 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] pat(input logic [4:0] n);
    pat = {11'h000, n, 8'hA4, 3'h0, n};
  endfunction
  function automatic logic [31:0] exp_of(input logic [4:0] n);
    case (n)
      5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0A, 5'h0D, 5'h0E, 5'h0F: exp_of = pat(n);
      5'h04: exp_of = LINES & pat(5'h03);
      5'h05: exp_of = PID;
      default: exp_of = 32'h0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk(state_q, 32'h0);
    // Number 0 skipped here: state is written on its own below to enter user mode
    for (int i = 1; i < 32; i++)
      acc(1'b0, i[4:0], pat(i[4:0]));
    for (int i = 1; i < 32; i++)
    begin
      acc(1'b1, i[4:0], 32'h0);
      chk(got, exp_of(i[4:0]));
      chk(got_b, exp_b_of(i[4:0]));
    end
    chk(irq_mask_q, pat(5'h03));
    chk(irq_wait_q, LINES & pat(5'h03));
    chk(core_cfg_q, pat(5'h0D));
    chk(mask_b, 32'h0);
    chk(wait_b, 32'h0);
    chk(cfg_b, pat(5'h0D));
    $display("register map test done");
    acc(1'b0, 5'h00, 32'h00000002);
    usr = 1'b1;
    chk(state_q, 32'h00000002);
    acc(1'b1, 5'h05, 32'h0);
    chk(got, 32'h0);
    acc(1'b0, 5'h03, 32'hFFFFFFFF);
    cause = 32'h00000018;
    addr = 32'h00001234;
    exc_entry = 1'b1;
    @(negedge clk);
    exc_entry = 1'b0;
    usr = 1'b0;
    chk(state_q, 32'h0);
    chk(state_b, 32'h0);
    acc(1'b1, 5'h01, 32'h0);
    chk(got, 32'h00000002);
    acc(1'b1, 5'h03, 32'h0);
    chk(got, pat(5'h03));
    acc(1'b1, 5'h07, 32'h0);
    chk(got, 32'h00000018);
    chk(got_b, 32'h00000018);
    acc(1'b1, 5'h0C, 32'h0);
    chk(got, 32'h00001234);
    chk(got_b, 32'h00001234);
    acc(1'b0, 5'h05, 32'hFFFFFFFF);
    acc(1'b1, 5'h05, 32'h0);
    chk(got, PID);
    chk(got_b, PID_B);
    exc_return = 1'b1;
    @(negedge clk);
    exc_return = 1'b0;
    usr = 1'b1;
    chk(state_q, 32'h00000002);
    brk_entry = 1'b1;
    @(negedge clk);
    brk_entry = 1'b0;
    usr = 1'b0;
    chk(state_b, 32'h0);
    acc(1'b1, 5'h02, 32'h0);
    chk(got, 32'h00000002);
    brk_return = 1'b1;
    @(negedge clk);
    brk_return = 1'b0;
    usr = 1'b1;
    chk(state_q, 32'h00000002);
    acc(1'b1, 5'h02, 32'h0);
    chk(got, 32'h0);
    $display("user mode test done");
    finish_test();
  end
  initial
  begin
    #5000;
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
